// file: src/bridge_spi_diag_pkg.sv
// Constants shared by the serial diagnostics slave and its synchroniser.
// Assumes an SPI master that stops the serial clock while chip select is high.
package bridge_spi_diag_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_BITS_5 = 5'h10;
  localparam logic [4:0] HALF_BITS_5 = 5'h08;
  localparam logic [1:0] CHIP_ADDRESS = 2'h0;
  // Opcode field values
  localparam logic [5:0] OP_READ_IDENTIFIER = 6'h00;
  localparam logic [5:0] OP_READ_REVISION = 6'h03;
  localparam logic [5:0] OP_READ_DIAGNOSTICS = 6'h09;
  localparam logic [5:0] OP_READ_STAGE_CONFIG = 6'h30;
  localparam logic [5:0] OP_READ_SUPPLY_MONITOR = 6'h3c;
  localparam logic [5:0] OP_WRITE_STAGE_CONFIG = 6'h28;
  localparam logic [5:0] OP_WRITE_SUPPLY_MONITOR = 6'h18;
  // Answers and patterns
  localparam logic [7:0] DATA_UNUSED_OP = 8'hff;
  localparam logic [7:0] DATA_WRITE_ACK = 8'h00;
  localparam logic [4:0] CHECK_PATTERN = 5'h15;
  // Reset values and diagnostic codes
  localparam logic [7:0] STAGE_CONFIG_RESET = 8'hfa;
  localparam logic [2:0] MONITOR_CONFIG_RESET = 3'h6;
  localparam logic [2:0] FLAGS_RESET = 3'h7;
  localparam logic [3:0] OUT_DIAG_RESET = 4'hf;
  localparam logic [3:0] OUT_DIAG_UV = 4'h0;
  localparam logic [3:0] OUT_DIAG_LOAD_SHORT_A = 4'h6;
  localparam logic [3:0] OUT_DIAG_LOAD_SHORT_B = 4'h9;
  localparam logic [3:0] OUT_DIAG_OPEN_BRIDGE = 4'hc;
  localparam logic [1:0] PAIR_OK = 2'h3;
  localparam logic [1:0] PAIR_SHORT_BATT = 2'h1;
  localparam logic [1:0] PAIR_SHORT_GND = 2'h2;
  // Field positions
  localparam int CFG_MODE_BIT = 7;
  localparam int CFG_RESET_BIT = 1;
  localparam int MON_DIACLR2_BIT = 4;
  localparam int MON_DIACLR1_BIT = 3;
  // Synchroniser lanes
  localparam int SYNC_W = 19;
  localparam int SY_CS_N = 0;
  localparam int SY_ABE = 1;
  localparam int SY_DIS = 2;
  localparam int SY_OT = 3;
  localparam int SY_CR = 4;
  localparam int SY_CL = 5;
  localparam int SY_SCB1 = 6;
  localparam int SY_SCB2 = 7;
  localparam int SY_SCG1 = 8;
  localparam int SY_SCG2 = 9;
  localparam int SY_SH12 = 10;
  localparam int SY_SH21 = 11;
  localparam int SY_OL1 = 12;
  localparam int SY_OL2 = 13;
  localparam int SY_MUV = 14;
  localparam int SY_LUV = 15;
  localparam int SY_VDD_UNDER = 16;
  localparam int SY_VDD_OVER = 17;
  localparam int SY_SPARE = 18;
endpackage

// file: src/bridge_spi_diag_slave.sv
// Serial frame decoder and latched diagnostics of a motor-driver power stage.
// Assumes the master keeps chip select high for at least six system clocks between frames.
`timescale 1ns/1ns
module bridge_spi_diag_slave #(
  // Arbitrary value
  parameter logic [7:0] PART_TYPE_CODE = 8'h5a,
  parameter logic [3:0] SOFTWARE_RELEASE_REV = 4'h1,
  parameter logic [3:0] MASK_SET_REV = 4'h1
) (
  // System
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // Enable pins
  input wire logic i_bridge_enable_input,
  input wire logic i_stage_disable_input,
  // Fault detectors, active high
  input wire logic i_overtemp,
  input wire logic i_thermal_current_reduction,
  input wire logic i_current_limit,
  input wire logic [1:0] i_short_to_battery,
  input wire logic [1:0] i_short_to_ground,
  input wire logic i_short_hs1_ls2,
  input wire logic i_short_hs2_ls1,
  input wire logic [1:0] i_open_load,
  input wire logic i_motor_supply_uv,
  input wire logic i_logic_supply_uv,
  input wire logic i_vdd_under,
  input wire logic i_vdd_over,
  // Power stage control
  output logic [7:0] o_stage_config,
  output logic [2:0] o_monitor_config,
  output logic [1:0] o_output_off
);
  pin_sync_if #(.W(bridge_spi_diag_pkg::SYNC_W)) lanes ();

  logic [bridge_spi_diag_pkg::SYNC_W-1:0] s;
  logic fresh_reg;

  // Spare lane carries the link-side fresh marker, so a frame with no clock edge is caught
  assign lanes.raw = {fresh_reg, i_vdd_over, i_vdd_under, i_logic_supply_uv, i_motor_supply_uv,
                      i_open_load[1], i_open_load[0], i_short_hs2_ls1, i_short_hs1_ls2,
                      i_short_to_ground[1], i_short_to_ground[0],
                      i_short_to_battery[1], i_short_to_battery[0],
                      i_current_limit, i_thermal_current_reduction, i_overtemp,
                      i_stage_disable_input, i_bridge_enable_input, i_cs_n};
  assign s = lanes.synced;

  pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .lanes(lanes)
  );

  // Link side, falling edge: receive
  logic fresh_next;
  logic [4:0] ncnt_reg;
  logic [4:0] ncnt_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;

  always_comb begin
    fresh_next = 1'b0;
    ncnt_next = fresh_reg ? 5'h01 : ((ncnt_reg > bridge_spi_diag_pkg::FRAME_BITS_5) ? ncnt_reg :
                ncnt_reg + 5'h01);
    shift_next = {shift_reg[14:0], i_mosi};
  end

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= fresh_next;
    end
  end

  // Count and word survive select rise so the system side can read them
  always_ff @(negedge i_sck) begin
    if (!i_cs_n) begin
      ncnt_reg <= ncnt_next;
      shift_reg <= shift_next;
    end
  end

  // Snapshots held stable while a frame runs
  logic [7:0] bank_diag_reg;
  logic [7:0] bank_cfg_reg;
  logic [7:0] bank_mon_reg;
  logic bank_tf_reg;

  // Link side, rising edge: transmit
  logic [4:0] pcnt_reg;
  logic [4:0] pcnt_next;
  logic aok_reg;
  logic aok_next;
  logic [7:0] dreg_reg;
  logic [7:0] dreg_next;
  logic miso_reg;
  logic miso_next;
  logic oe_reg;
  logic oe_next;
  logic [7:0] lookup;

  always_comb begin
    unique case (shift_reg[5:0])
      bridge_spi_diag_pkg::OP_READ_IDENTIFIER: lookup = PART_TYPE_CODE;
      bridge_spi_diag_pkg::OP_READ_REVISION: lookup = {SOFTWARE_RELEASE_REV, MASK_SET_REV};
      bridge_spi_diag_pkg::OP_READ_DIAGNOSTICS: lookup = bank_diag_reg;
      bridge_spi_diag_pkg::OP_READ_STAGE_CONFIG: lookup = bank_cfg_reg;
      bridge_spi_diag_pkg::OP_READ_SUPPLY_MONITOR: lookup = bank_mon_reg;
      bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG: lookup = bridge_spi_diag_pkg::DATA_WRITE_ACK;
      bridge_spi_diag_pkg::OP_WRITE_SUPPLY_MONITOR: lookup = bridge_spi_diag_pkg::DATA_WRITE_ACK;
      default: lookup = bridge_spi_diag_pkg::DATA_UNUSED_OP;
    endcase
  end

  always_comb begin
    pcnt_next = (pcnt_reg > bridge_spi_diag_pkg::FRAME_BITS_5) ? pcnt_reg : pcnt_reg + 5'h01;
    aok_next = aok_reg;
    dreg_next = dreg_reg;
    miso_next = 1'b0;
    oe_next = 1'b0;
    if (pcnt_reg == 5'h02) begin
      aok_next = (shift_reg[1:0] == bridge_spi_diag_pkg::CHIP_ADDRESS);
    end
    if (pcnt_reg < bridge_spi_diag_pkg::HALF_BITS_5) begin
      if (pcnt_reg == 5'h07) begin
        miso_next = bank_tf_reg;
      end else if (pcnt_reg >= 5'h02) begin
        miso_next = bridge_spi_diag_pkg::CHECK_PATTERN[3'h6 - pcnt_reg[2:0]];
      end
    end else if (pcnt_reg == bridge_spi_diag_pkg::HALF_BITS_5) begin
      dreg_next = lookup;
      miso_next = lookup[7];
    end else if (pcnt_reg < bridge_spi_diag_pkg::FRAME_BITS_5) begin
      miso_next = dreg_reg[3'h7 - pcnt_reg[2:0]];
    end
    if (pcnt_reg >= 5'h02 && pcnt_reg < bridge_spi_diag_pkg::FRAME_BITS_5) begin
      oe_next = (pcnt_reg == 5'h02) ? aok_next : aok_reg;
    end
  end

  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      pcnt_reg <= 5'h00;
      aok_reg <= 1'b0;
      dreg_reg <= 8'h00;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      pcnt_reg <= pcnt_next;
      aok_reg <= aok_next;
      dreg_reg <= dreg_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
    end
  end

  assign o_miso = miso_reg;
  assign o_miso_oe = oe_reg;

  // System side
  logic cs_prev_reg;
  logic en_prev_reg;
  logic edge_seen_reg;
  logic edge_seen_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [2:0] mon_reg;
  logic [2:0] mon_next;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [3:0] od_reg;
  logic [3:0] od_next;
  logic tf_reg;
  logic tf_next;
  logic [1:0] off_reg;
  logic [1:0] off_next;
  logic en;
  logic frame_end;
  logic addr_ok;
  logic count_ok;
  logic known;
  logic do_write;
  logic spi_reset;
  logic diag_reset;
  logic [1:0] shorted;
  logic [7:0] diag_view;
  logic [7:0] mon_view;

  always_comb begin
    en = s[bridge_spi_diag_pkg::SY_ABE] & ~s[bridge_spi_diag_pkg::SY_DIS];
    frame_end = s[bridge_spi_diag_pkg::SY_CS_N] & ~cs_prev_reg;
    addr_ok = (shift_reg[15:14] == bridge_spi_diag_pkg::CHIP_ADDRESS);
    // exactly sixteen falling edges; a frame without any leaves a stale count
    edge_seen_next = ~(s[bridge_spi_diag_pkg::SY_CS_N] & cs_prev_reg) &
                     (edge_seen_reg | ~s[bridge_spi_diag_pkg::SY_SPARE]);
    count_ok = edge_seen_reg && (ncnt_reg == bridge_spi_diag_pkg::FRAME_BITS_5);
    unique case (shift_reg[13:8])
      bridge_spi_diag_pkg::OP_READ_IDENTIFIER,
      bridge_spi_diag_pkg::OP_READ_REVISION,
      bridge_spi_diag_pkg::OP_READ_DIAGNOSTICS,
      bridge_spi_diag_pkg::OP_READ_STAGE_CONFIG,
      bridge_spi_diag_pkg::OP_READ_SUPPLY_MONITOR,
      bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG,
      bridge_spi_diag_pkg::OP_WRITE_SUPPLY_MONITOR: known = 1'b1;
      default: known = 1'b0;
    endcase
    do_write = frame_end & addr_ok & count_ok;
    mon_view = {mon_reg, 2'h3, s[bridge_spi_diag_pkg::SY_ABE],
                ~s[bridge_spi_diag_pkg::SY_VDD_UNDER], ~s[bridge_spi_diag_pkg::SY_VDD_OVER]};
    diag_view = {en, flags_reg, s[bridge_spi_diag_pkg::SY_MUV] ? bridge_spi_diag_pkg::OUT_DIAG_UV : od_reg};
  end

  always_comb begin
    cfg_next = cfg_reg;
    mon_next = mon_reg;
    flags_next = flags_reg;
    od_next = od_reg;
    tf_next = tf_reg;
    spi_reset = 1'b0;
    if (do_write && shift_reg[13:8] == bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG) begin
      cfg_next = shift_reg[7:0];
      spi_reset = ~shift_reg[bridge_spi_diag_pkg::CFG_RESET_BIT];
    end
    if (do_write && shift_reg[13:8] == bridge_spi_diag_pkg::OP_WRITE_SUPPLY_MONITOR) begin
      mon_next = shift_reg[7:5];
      if (!shift_reg[bridge_spi_diag_pkg::MON_DIACLR2_BIT]) begin
        od_next[3:2] = bridge_spi_diag_pkg::PAIR_OK;
      end
      if (!shift_reg[bridge_spi_diag_pkg::MON_DIACLR1_BIT]) begin
        od_next[1:0] = bridge_spi_diag_pkg::PAIR_OK;
      end
    end
    if (do_write && shift_reg[13:8] == bridge_spi_diag_pkg::OP_READ_DIAGNOSTICS) begin
      flags_next = bridge_spi_diag_pkg::FLAGS_RESET;
    end
    diag_reset = i_srst | spi_reset | s[bridge_spi_diag_pkg::SY_LUV] | (en != en_prev_reg);
    if (diag_reset) begin
      flags_next = bridge_spi_diag_pkg::FLAGS_RESET;
      od_next = bridge_spi_diag_pkg::OUT_DIAG_RESET;
    end
    if (i_srst || spi_reset) begin
      cfg_next = bridge_spi_diag_pkg::STAGE_CONFIG_RESET;
      mon_next = bridge_spi_diag_pkg::MONITOR_CONFIG_RESET;
    end
    flags_next = flags_next & ~{s[bridge_spi_diag_pkg::SY_OT], s[bridge_spi_diag_pkg::SY_CR],
                                s[bridge_spi_diag_pkg::SY_CL]};
    if (!s[bridge_spi_diag_pkg::SY_MUV]) begin
      if (en) begin
        if (s[bridge_spi_diag_pkg::SY_SH12] && od_next == bridge_spi_diag_pkg::OUT_DIAG_RESET) begin
          od_next = bridge_spi_diag_pkg::OUT_DIAG_LOAD_SHORT_A;
        end else if (s[bridge_spi_diag_pkg::SY_SH21] && od_next == bridge_spi_diag_pkg::OUT_DIAG_RESET) begin
          od_next = bridge_spi_diag_pkg::OUT_DIAG_LOAD_SHORT_B;
        end else begin
          if (od_next[1:0] == bridge_spi_diag_pkg::PAIR_OK) begin
            if (s[bridge_spi_diag_pkg::SY_SCB1]) begin
              od_next[1:0] = bridge_spi_diag_pkg::PAIR_SHORT_BATT;
            end else if (s[bridge_spi_diag_pkg::SY_SCG1]) begin
              od_next[1:0] = bridge_spi_diag_pkg::PAIR_SHORT_GND;
            end
          end
          if (od_next[3:2] == bridge_spi_diag_pkg::PAIR_OK) begin
            if (s[bridge_spi_diag_pkg::SY_SCB2]) begin
              od_next[3:2] = bridge_spi_diag_pkg::PAIR_SHORT_BATT;
            end else if (s[bridge_spi_diag_pkg::SY_SCG2]) begin
              od_next[3:2] = bridge_spi_diag_pkg::PAIR_SHORT_GND;
            end
          end
        end
      end else if (cfg_reg[bridge_spi_diag_pkg::CFG_MODE_BIT]) begin
        if (s[bridge_spi_diag_pkg::SY_OL1] || s[bridge_spi_diag_pkg::SY_OL2]) begin
          od_next = bridge_spi_diag_pkg::OUT_DIAG_OPEN_BRIDGE;
        end
      end else begin
        if (s[bridge_spi_diag_pkg::SY_OL1]) begin
          od_next[0] = 1'b0;
        end
        if (s[bridge_spi_diag_pkg::SY_OL2]) begin
          od_next[1] = 1'b0;
        end
      end
    end
    // fault of this frame shows next frame
    if (frame_end && addr_ok) begin
      if (!count_ok || !known) begin
        tf_next = 1'b1;
      end else if (edge_seen_reg && ncnt_reg >= bridge_spi_diag_pkg::HALF_BITS_5) begin
        tf_next = 1'b0;
      end
    end
    if (i_srst) begin
      tf_next = 1'b0;
    end
  end

  always_comb begin
    shorted[0] = (od_reg[1:0] == bridge_spi_diag_pkg::PAIR_SHORT_BATT) ||
                 (od_reg[1:0] == bridge_spi_diag_pkg::PAIR_SHORT_GND);
    shorted[1] = (od_reg[3:2] == bridge_spi_diag_pkg::PAIR_SHORT_BATT) ||
                 (od_reg[3:2] == bridge_spi_diag_pkg::PAIR_SHORT_GND);
    if (!en || s[bridge_spi_diag_pkg::SY_MUV] || i_srst) begin
      off_next = 2'h3;
    end else if (cfg_reg[bridge_spi_diag_pkg::CFG_MODE_BIT]) begin
      off_next = {2{|shorted}};
    end else begin
      off_next = shorted;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    cs_prev_reg <= i_srst ? 1'b1 : s[bridge_spi_diag_pkg::SY_CS_N];
    en_prev_reg <= en;
    edge_seen_reg <= edge_seen_next;
    cfg_reg <= cfg_next;
    mon_reg <= mon_next;
    flags_reg <= flags_next;
    od_reg <= od_next;
    tf_reg <= tf_next;
    off_reg <= off_next;
  end

  // Snapshots only move between frames, so the link side sees steady words
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || (s[bridge_spi_diag_pkg::SY_CS_N] && cs_prev_reg)) begin
      bank_diag_reg <= diag_view;
      bank_cfg_reg <= cfg_reg;
      bank_mon_reg <= mon_view;
      bank_tf_reg <= tf_reg;
    end
  end

  assign o_stage_config = cfg_reg;
  assign o_monitor_config = mon_reg;
  assign o_output_off = off_reg;
endmodule // bridge_spi_diag_slave

// file: src/pin_sync.sv
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each lane is an independent slow level.
`timescale 1ns/1ns
module pin_sync (
  // Clock
  input wire logic i_clk_sys,
  // Lanes
  pin_sync_if.dst lanes
);
  logic [$bits(lanes.raw)-1:0] meta_reg;
  logic [$bits(lanes.raw)-1:0] meta_next;
  logic [$bits(lanes.raw)-1:0] sync_reg;
  logic [$bits(lanes.raw)-1:0] sync_next;

  always_comb begin
    meta_next = lanes.raw;
    sync_next = meta_reg;
  end

  // Stage one is read only by stage two
  always_ff @(posedge i_clk_sys) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign lanes.synced = sync_reg;
endmodule // pin_sync

// file: src/pin_sync_if.sv
// Carrier between the pin synchroniser and the frame logic.
// Assumes raw lanes come straight from pins, except the spare lane, which carries the link-side fresh marker register.
`timescale 1ns/1ns
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// file: tb/bridge_spi_diag_slave_properties.sv
// Port checker of the serial diagnostics slave.
// Assumes the master stops the serial clock while chip select is high.
`timescale 1ns/1ns
module bridge_spi_diag_checker (
  // System
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic o_miso,
  input wire logic o_miso_oe,
  // Stage side
  input wire logic i_motor_supply_uv,
  input wire logic [7:0] o_stage_config,
  input wire logic [2:0] o_monitor_config,
  input wire logic [1:0] o_output_off
);
  logic [4:0] rise_reg;
  logic [4:0] fall_reg;
  logic [7:0] instr_reg;
  logic [1:0] addr_reg;
  // Counters are cleared by chip select, like the link side's rising-edge counter
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) rise_reg <= 5'h00;
    else rise_reg <= rise_reg + 5'h01;
  end
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      fall_reg <= 5'h00;
      instr_reg <= 8'h00;
      addr_reg <= 2'h0;
    end else begin
      fall_reg <= fall_reg + 5'h01;
      if (fall_reg < 5'h08) instr_reg <= {instr_reg[6:0], i_mosi};
      if (fall_reg < 5'h02) addr_reg <= {addr_reg[0], i_mosi};
    end
  end
  a_cs_release: assert property (@(posedge i_clk_sys) disable iff (i_srst) i_cs_n |-> !o_miso_oe)
    else $error("data line driven while deselected");
  a_addr_released: assert property (@(negedge i_sck) disable iff (i_cs_n) rise_reg <= 5'h02 |-> !o_miso_oe)
    else $error("data line driven in address phase");
  a_foreign_silent: assert property (@(negedge i_sck) disable iff (i_cs_n)
    (rise_reg >= 5'h03 && addr_reg != 2'h0) |-> !o_miso_oe) else $error("foreign frame answered");
  a_check_pattern: assert property (@(negedge i_sck) disable iff (i_cs_n)
    (rise_reg inside {[5'h03:5'h07]} && addr_reg == 2'h0)
    |-> o_miso_oe && o_miso == bridge_spi_diag_pkg::CHECK_PATTERN[5'h07 - rise_reg])
    else $error("verification pattern wrong");
  a_write_ack: assert property (@(negedge i_sck) disable iff (i_cs_n)
    (rise_reg >= 5'h09 && instr_reg inside {8'h28, 8'h18}) |-> o_miso_oe && !o_miso)
    else $error("write data byte not zero");
  a_unused_ff: assert property (@(negedge i_sck) disable iff (i_cs_n)
    (rise_reg >= 5'h09 && instr_reg[7:6] == 2'h0
    && !(instr_reg[5:0] inside {6'h00, 6'h03, 6'h09, 6'h18, 6'h28, 6'h30, 6'h3c})) |-> o_miso_oe && o_miso)
    else $error("unused opcode data byte not ones");
  a_write_at_cs: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!$stable(o_stage_config) || !$stable(o_monitor_config)) |-> i_cs_n && $past(i_cs_n, 2))
    else $error("register changed inside a frame");
  a_uv_outputs_off: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_motor_supply_uv [*6] |-> o_output_off == 2'h3) else $error("outputs on during motor undervoltage");
endmodule // bridge_spi_diag_checker
bind bridge_spi_diag_slave bridge_spi_diag_checker u_checker (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_mosi(i_mosi),
  .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_motor_supply_uv(i_motor_supply_uv),
  .o_stage_config(o_stage_config), .o_monitor_config(o_monitor_config), .o_output_off(o_output_off));

// file: tb/spi_master_model.sv
// Serial bus master model for the diagnostics slave.
// Assumes the slave drives its data line only while its enable is high.
`timescale 1ns/1ns
module spi_master_model (
  // Serial link
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe,
  // Received frame
  output logic [15:0] o_rx_word,
  output logic [15:0] o_rx_oe,
  output logic o_rx_done
);
  logic last_bit;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_mosi = 1'b0;
    o_rx_done = 1'b0;
    o_rx_word = 16'h0000;
    o_rx_oe = 16'h0000;
    last_bit = 1'b0;
    // A select rise at start clears the transmit side and sets the fresh marker before any frame
    #1 o_cs_n = 1'b1;
  end
  // msb first, clock still between frames
  task automatic frame(input logic [15:0] word, input int nbits);
    o_cs_n = 1'b0;
    for (int k = 15; k > 15 - nbits; k--) begin
      #6 o_sck = 1'b1;
      o_mosi = word[k];
      #6 o_sck = 1'b0;
      // Released line shows the inverse of its last level, so a stale value never passes
      o_rx_word[k] = i_miso_oe ? i_miso : ~last_bit;
      o_rx_oe[k] = i_miso_oe;
      if (i_miso_oe) last_bit = i_miso;
    end
    #6 o_cs_n = 1'b1;
    o_mosi = ~o_mosi;
    if (nbits == 16) o_rx_done = ~o_rx_done;
  endtask
endmodule // spi_master_model

// file: tb/tb_top.sv
// Self-checking bench of the serial diagnostics slave.
// Assumes the master model reports each full frame by toggling its done line.
`timescale 1ns/1ns
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic en = 1'b1;
  logic dis = 1'b0;
  logic muv = 1'b0;
  logic luv = 1'b0;
  logic [1:0] vdd = 2'h0;
  logic [10:0] flt = 11'h000;
  logic sck, cs_n, mosi, miso, miso_oe, rx_done;
  logic [15:0] rx_word, rx_oe;
  logic [7:0] stage_config, cfg;
  logic [2:0] monitor_config, mon;
  logic [1:0] output_off;
  logic fault_exp = 1'b0;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  spi_master_model u_master (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso), .i_miso_oe(miso_oe),
    .o_rx_word(rx_word), .o_rx_oe(rx_oe), .o_rx_done(rx_done));
  // Arbitrary identifier value
  bridge_spi_diag_slave #(.PART_TYPE_CODE(8'h3c), .SOFTWARE_RELEASE_REV(4'h2), .MASK_SET_REV(4'h7)) DUT (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe(miso_oe), .i_bridge_enable_input(en), .i_stage_disable_input(dis), .i_overtemp(flt[0]),
    .i_thermal_current_reduction(flt[1]), .i_current_limit(flt[2]), .i_short_to_battery(flt[4:3]),
    .i_short_to_ground(flt[6:5]), .i_short_hs1_ls2(flt[7]), .i_short_hs2_ls1(flt[8]), .i_open_load(flt[10:9]),
    .i_motor_supply_uv(muv), .i_logic_supply_uv(luv), .i_vdd_under(vdd[1]), .i_vdd_over(vdd[0]),
    .o_stage_config(stage_config), .o_monitor_config(monitor_config), .o_output_off(output_off));
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic [15:0] w, input int n, input logic [7:0] data, input logic bad);
    logic ours;
    ours = (w[15:14] == 2'h0);
    if (n == 16) exp_q.push_back(ours ? {16'h3fff, 2'h0, bridge_spi_diag_pkg::CHECK_PATTERN, fault_exp, data} : 32'h0);
    u_master.frame(w, n);
    if (ours) fault_exp = (n != 16) || bad;
    // Gap lets the frame be acted on before the next one starts
    wait_clk(10);
  endtask
  task automatic rd(input logic [5:0] opc, input logic [7:0] data);
    xfer({2'h0, opc, 8'($urandom)}, 16, data, 1'b0);
  endtask
  task automatic wr(input logic [5:0] opc, input logic [7:0] val);
    xfer({2'h0, opc, val}, 16, 8'h00, 1'b0);
  endtask
  task automatic rdd(input logic [7:0] data);
    rd(bridge_spi_diag_pkg::OP_READ_DIAGNOSTICS, data);
  endtask
  task automatic pulse(input logic [10:0] mask);
    flt = mask;
    wait_clk(5);
    flt = 11'h000;
    wait_clk(5);
  endtask
  initial begin
    void'($urandom(32'h519c50b4));
    vdd = 2'($urandom);
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_srst = 1'b0;
    wait_clk(10);
    rdd(8'hff);
    rd(bridge_spi_diag_pkg::OP_READ_IDENTIFIER, 8'h3c);
    rd(bridge_spi_diag_pkg::OP_READ_REVISION, 8'h27);
    rd(bridge_spi_diag_pkg::OP_READ_STAGE_CONFIG, 8'hfa);
    rd(bridge_spi_diag_pkg::OP_READ_SUPPLY_MONITOR, {5'h1b, en, ~vdd});
    cfg = (8'($urandom) & 8'h7d) | 8'h02;
    mon = 3'($urandom);
    wr(bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG, cfg);
    wr(bridge_spi_diag_pkg::OP_WRITE_SUPPLY_MONITOR, {mon, 5'h18});
    check("stage_config", {24'h0, stage_config}, {24'h0, cfg});
    check("monitor_config", {29'h0, monitor_config}, {29'h0, mon});
    rd(bridge_spi_diag_pkg::OP_READ_SUPPLY_MONITOR, {mon, 2'h3, en, ~vdd});
    for (int i = 0; i < 3; i++) xfer({2'h0, 6'h3d + 6'(i), 8'($urandom)}, 16, 8'hff, 1'b1);
    rd(bridge_spi_diag_pkg::OP_READ_IDENTIFIER, 8'h3c);
    rd(bridge_spi_diag_pkg::OP_READ_IDENTIFIER, 8'h3c);
    // foreign and short frames leave the config alone
    xfer({2'h1 + 2'($urandom % 3), bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG, 8'h00}, 16, 8'h00, 1'b0);
    xfer({2'h0, bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG, 8'h00}, 12, 8'h00, 1'b0);
    rd(bridge_spi_diag_pkg::OP_READ_STAGE_CONFIG, cfg);
    pulse(11'h001);
    rdd(8'hbf);
    rdd(8'hff);
    flt = 11'h002;
    wait_clk(5);
    rdd(8'hdf);
    rdd(8'hdf);
    pulse(11'h008);
    rdd(8'hdd);
    check("output_off", {30'h0, output_off}, 32'h1);
    // masked while motor supply is low
    muv = 1'b1;
    wait_clk(5);
    rdd(8'hf0);
    muv = 1'b0;
    wait_clk(5);
    rdd(8'hfd);
    dis = 1'b1;
    wait_clk(5);
    rdd(8'h7f);
    dis = 1'b0;
    wait_clk(5);
    check("output_off", {30'h0, output_off}, 32'h0);
    pulse(11'h040);
    rdd(8'hfb);
    check("output_off", {30'h0, output_off}, 32'h2);
    wr(bridge_spi_diag_pkg::OP_WRITE_STAGE_CONFIG, 8'h00);
    check("stage_config", {24'h0, stage_config}, 32'hfa);
    rdd(8'hff);
    pulse(11'h080);
    rdd(8'hf6);
    luv = 1'b1;
    wait_clk(5);
    luv = 1'b0;
    wait_clk(5);
    rdd(8'hff);
    pulse(11'h100);
    rdd(8'hf9);
    check("output_off", {30'h0, output_off}, 32'h3);
    en = 1'b0;
    wait_clk(5);
    pulse(11'h600);
    rdd(8'h7c);
    en = 1'b1;
    wait_clk(5);
    rdd(8'hff);
    print_verdict();
  end
  initial begin
    #1;
    forever begin
      @(rx_done);
      check("frame", {rx_oe, rx_word & rx_oe}, exp_q.pop_front());
    end
  end
  initial begin
    #60000;
    err_count++;
    print_verdict();
  end
endmodule // tb_top
